//--- src/rx_buffer_defines.vh
`ifndef RX_BUFFER_DEFINES_VH
`define RX_BUFFER_DEFINES_VH

// Negative acknowledgement reasons
`define NAK_NONE 2'h0
`define NAK_UNAVAIL 2'h1
`define NAK_TOOSMALL 2'h2

// Response kinds posted to the host
`define RSP_RXDONE 3'h0
`define RSP_NAK 3'h1
`define RSP_NXM 3'h2
`define RSP_BABBLE 3'h3
`define RSP_STREAM 3'h4
`define RSP_BUFRET 3'h5

// Boot request reasons
`define BOOT_POWERON 1'h0
`define BOOT_INVOKE 1'h1

// Retrieval window after overflow
`define CLK_PERIOD_NS 10
`define RETRIEVE_WINDOW_MS 3000
`define RETRIEVE_CYCLES (`RETRIEVE_WINDOW_MS * (1000000 / `CLK_PERIOD_NS))

`endif

//--- src/resp_fifo.v
`timescale 1ns/1ps
// ********************************
// Response FIFO
// ********************************
module resp_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   input wire flush,
   // Fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // Drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData,
   output wire [AW:0] level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr;
   reg [AW-1:0] rdPtr;
   reg [AW:0] count;
   wire doWrite;
   wire doRead;

   assign inReady = (count != DEPTH[AW:0]);
   assign outValid = (count != {(AW+1){1'b0}});
   assign outData = mem[rdPtr];
   assign level = count;
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   always @(posedge mclk) begin
      if (doWrite) begin
         mem[wrPtr] <= inData;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else if (flush) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (doWrite) begin
            wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (doRead) begin
            rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
         end
         case ({doWrite, doRead})
            2'b10: count <= count + {{AW{1'b0}}, 1'b1};
            2'b01: count <= count - {{AW{1'b0}}, 1'b1};
            default: count <= count;
         endcase
      end
   end
endmodule

//--- src/sync2.v
`timescale 1ns/1ps
// ********************************
// Two-stage synchroniser
// ********************************
module sync2 #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Data
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] stage1;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

//--- src/rx_buffer_ctrl.v
// Summary of operation
// - Bad buffer address posts failing address
// - Reported address may be one past
// - Drop out-of-sequence messages silently
// - Pool tried only if enabled, quota, available
// - Small pool buffer, no private: NAK small
// - No private buffer: NAK temporarily unavailable
// - Small private buffer NAK, else use
// - Only list head examined, no search
// - Too-small only for receive buffers
// - Halt returns tributary's outstanding buffers
// - Global halt returns pool receive buffers
// - No free link block: fatal overflow
// - Overflow: post pending or queue head, interrupt, three seconds
// - Each retrieval posts next queued response
// - Queue empty or timeout: shut down
// - Timer expiry raises babble, else stream, in run state if no NXM
// - Power-on boot answers first poll
// - Host request starts boot request
// - Boot needs hardware switch configuration
`timescale 1ns/1ps
`include "rx_buffer_defines.vh"
module rx_buffer_ctrl #(
   parameter TRIB_W = 4,
   parameter LEN_W = 12,
   parameter ADDR_W = 18,
   parameter SEQ_W = 8,
   parameter RETRIEVE_CYCLES = `RETRIEVE_CYCLES,
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW = 5
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Received message from the link
   input wire msgValid,
   input wire [TRIB_W-1:0] msgTrib,
   input wire [SEQ_W-1:0] msgSeq,
   input wire [SEQ_W-1:0] expSeq,
   input wire [LEN_W-1:0] msgLen,
   // Buffer list heads for the tributary
   input wire poolEnable,
   input wire poolQuotaZero,
   input wire poolAvail,
   input wire [LEN_W-1:0] poolSize,
   input wire privAvail,
   input wire [LEN_W-1:0] privSize,
   // Buffer decision
   output reg takePool,
   output reg takePriv,
   output reg nakValid,
   output reg [1:0] nakReason,
   // Memory access faults
   input wire nxmValid,
   input wire [ADDR_W-1:0] nxmAddr,
   // Timers
   input wire babbleExpired,
   input wire streamExpired,
   // Halts
   input wire haltTrib,
   input wire [TRIB_W-1:0] haltTribId,
   input wire globalHalt,
   output reg returnTrib,
   output reg returnPool,
   // Response path to host
   input wire linkBlockFree,
   output reg rspValid,
   output reg [ADDR_W+2:0] rspData,
   input wire rspTake,
   output reg hostIrq,
   // Lifecycle
   input wire hostInit,
   output reg shutDown,
   // Boot
   input wire bootSwitchEn,
   input wire powerOnBootSw,
   input wire pollRx,
   input wire invokeBoot,
   output reg bootReq,
   output reg bootReason
);
   localparam RW = ADDR_W + 3;
   localparam ST_RUN = 2'h0;
   localparam ST_DRAIN = 2'h1;
   localparam ST_DEAD = 2'h2;
   localparam [31:0] WIN = RETRIEVE_CYCLES;

   // ********************************
   // Pin synchronisers
   // ********************************
   wire [1:0] swSync;
   sync2 #(.WIDTH(2)) swSyncInst (
      .mclk(mclk),
      .rst_n(rst_n),
      .din({bootSwitchEn, powerOnBootSw}),
      .dout(swSync)
   );

   // ********************************
   // Response FIFO
   // ********************************
   reg fifoInValid;
   reg [RW-1:0] fifoInData;
   wire fifoInReady;
   wire fifoOutValid;
   wire [RW-1:0] fifoOutData;
   reg fifoPop;
   reg fifoFlush;

   resp_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rspFifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .flush(fifoFlush),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOutData),
      .level()
   );

   function [RW-1:0] mkRsp;
      input [2:0] kind;
      input [ADDR_W-1:0] arg;
      begin
         mkRsp = {kind, arg};
      end
   endfunction

   // True when a message of len bytes fits a buffer of size bytes
   function fitsIn;
      input [LEN_W-1:0] len;
      input [LEN_W-1:0] size;
      begin
         fitsIn = (len <= size);
      end
   endfunction

   // ********************************
   // Buffer selection
   // ********************************
   // Only the head entries are seen; no list scan.
   reg selNak;
   reg [1:0] selReason;
   reg selPool;
   reg selPriv;
   reg poolTried;
   always @* begin
      selNak = 1'b0;
      selReason = `NAK_NONE;
      selPool = 1'b0;
      selPriv = 1'b0;
      poolTried = poolEnable && !poolQuotaZero && poolAvail;
      if (poolTried && fitsIn(msgLen, poolSize)) begin
         selPool = 1'b1;
      end else if (!privAvail) begin
         selNak = 1'b1;
         selReason = poolTried ? `NAK_TOOSMALL : `NAK_UNAVAIL;
      end else if (!fitsIn(msgLen, privSize)) begin
         selNak = 1'b1;
         selReason = `NAK_TOOSMALL;
      end else begin
         selPriv = 1'b1;
      end
   end

   // ********************************
   // Main control
   // ********************************
   reg [1:0] state;
   reg [31:0] winCount;
   reg pendValid;
   reg firstPollSeen;
   wire active;
   wire seqOk;
   wire overflow;
   wire winDone;
   assign active = (state == ST_RUN);
   assign seqOk = (msgSeq == expSeq);
   // A lost link block or a full queue is fatal either way
   assign overflow = !linkBlockFree || (fifoInValid && !fifoInReady);
   // Window counts from zero, so its last cycle is one short of the span
   assign winDone = (winCount >= WIN - 32'h00000001);

   // Highest-priority new response this cycle
   always @* begin
      fifoInValid = 1'b0;
      fifoInData = {RW{1'b0}};
      if (active) begin
         if (nxmValid) begin
            fifoInValid = 1'b1;
            fifoInData = mkRsp(`RSP_NXM, nxmAddr);
         end else if (babbleExpired) begin
            fifoInValid = 1'b1;
            fifoInData = mkRsp(`RSP_BABBLE, {ADDR_W{1'b0}});
         end else if (streamExpired) begin
            fifoInValid = 1'b1;
            fifoInData = mkRsp(`RSP_STREAM, {ADDR_W{1'b0}});
         end else if (msgValid && seqOk && selNak) begin
            fifoInValid = 1'b1;
            fifoInData = mkRsp(`RSP_NAK,
               {{(ADDR_W-TRIB_W-2){1'b0}}, selReason, msgTrib});
         end
      end
   end

   always @* begin
      fifoPop = 1'b0;
      fifoFlush = hostInit;
      if (active) begin
         fifoPop = (!pendValid || rspTake) && fifoOutValid;
      end else if (state == ST_DRAIN) begin
         fifoPop = rspTake && fifoOutValid;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RUN;
         winCount <= 32'h00000000;
         pendValid <= 1'b0;
         takePool <= 1'b0;
         takePriv <= 1'b0;
         nakValid <= 1'b0;
         nakReason <= `NAK_NONE;
         returnTrib <= 1'b0;
         returnPool <= 1'b0;
         rspValid <= 1'b0;
         rspData <= {RW{1'b0}};
         hostIrq <= 1'b0;
         shutDown <= 1'b0;
      end else begin
         takePool <= 1'b0;
         takePriv <= 1'b0;
         nakValid <= 1'b0;
         returnTrib <= 1'b0;
         returnPool <= 1'b0;
         hostIrq <= 1'b0;
         case (state)
            ST_RUN: begin
               // Out-of-sequence messages fall through unanswered
               if (msgValid && seqOk) begin
                  takePool <= selPool;
                  takePriv <= selPriv;
                  nakValid <= selNak;
                  nakReason <= selReason;
               end
               returnTrib <= haltTrib;
               returnPool <= globalHalt;
               // A retrieval and a new posting may share one cycle
               if (fifoPop) begin
                  pendValid <= 1'b1;
                  rspValid <= 1'b1;
                  rspData <= fifoOutData;
                  hostIrq <= 1'b1;
               end else if (rspTake) begin
                  pendValid <= 1'b0;
                  rspValid <= 1'b0;
               end
               // Drain only if something is left to hand over
               if (overflow) begin
                  winCount <= 32'h00000000;
                  if (fifoPop || (pendValid && !rspTake)) begin
                     state <= ST_DRAIN;
                     rspValid <= 1'b1;
                     hostIrq <= 1'b1;
                  end else begin
                     rspValid <= 1'b0;
                     state <= ST_DEAD;
                     shutDown <= 1'b1;
                  end
               end
            end
            ST_DRAIN: begin
               // Every retrieval restarts the window
               if (rspTake) begin
                  winCount <= 32'h00000000;
                  if (fifoOutValid) begin
                     rspData <= fifoOutData;
                     rspValid <= 1'b1;
                     hostIrq <= 1'b1;
                  end else begin
                     rspValid <= 1'b0;
                     state <= ST_DEAD;
                     shutDown <= 1'b1;
                  end
               end else if (winDone) begin
                  rspValid <= 1'b0;
                  state <= ST_DEAD;
                  shutDown <= 1'b1;
               end else begin
                  winCount <= winCount + 32'h00000001;
               end
            end
            ST_DEAD: begin
               // Nothing is taken from the link here; only host init is accepted
               if (hostInit) begin
                  state <= ST_RUN;
                  shutDown <= 1'b0;
                  pendValid <= 1'b0;
               end
            end
            default: begin
               state <= ST_DEAD;
               shutDown <= 1'b1;
            end
         endcase
      end
   end

   // ********************************
   // Boot requests
   // ********************************
   // Power-on request is owed only to the first poll after reset or an init out of shutdown
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bootReq <= 1'b0;
         bootReason <= `BOOT_POWERON;
         firstPollSeen <= 1'b0;
      end else begin
         bootReq <= 1'b0;
         if (state == ST_DEAD) begin
            if (hostInit) begin
               firstPollSeen <= 1'b0;
            end
         end else if (active) begin
            if (pollRx && !firstPollSeen) begin
               firstPollSeen <= 1'b1;
               if (swSync[1] && swSync[0]) begin
                  bootReq <= 1'b1;
                  bootReason <= `BOOT_POWERON;
               end
            end else if (invokeBoot && swSync[1]) begin
               bootReq <= 1'b1;
               bootReason <= `BOOT_INVOKE;
            end
         end
      end
   end
endmodule

//--- dv/rx_buffer_chk_sva.sv
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module rx_buffer_chk #(
   parameter LEN_W = 12,
   parameter SEQ_W = 8,
   parameter ADDR_W = 18
) (
   // Clock and reset
   input wire mclk, rst_n,
   // Message and list heads
   input wire msgValid, poolEnable, poolQuotaZero, poolAvail, privAvail,
   input wire [SEQ_W-1:0] msgSeq, expSeq,
   input wire [LEN_W-1:0] msgLen, poolSize, privSize,
   // Decision
   input wire takePool, takePriv, nakValid,
   input wire [1:0] nakReason,
   // Faults, halts, responses
   input wire nxmValid, haltTrib, globalHalt, returnTrib, returnPool,
   input wire babbleExpired, streamExpired,
   input wire [ADDR_W-1:0] nxmAddr,
   input wire linkBlockFree, rspValid, shutDown, hostInit,
   input wire [ADDR_W+2:0] rspData,
   // Boot
   input wire invokeBoot, bootSwitchEn, bootReq, bootReason
);
   wire ok = msgValid && msgSeq == expSeq && !shutDown && linkBlockFree;
   wire pl = poolEnable && !poolQuotaZero && poolAvail;
   wire pbig = poolSize >= msgLen;
   wire vbig = privSize >= msgLen;
   wire [4:0] dec = {takePool, takePriv, nakValid,
      nakValid ? nakReason : 2'h0};
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_seq_drop: assert property (msgValid && msgSeq != expSeq |=>
      dec == 5'h00) else $error("out of order message answered");
   a_pool_use: assert property (ok && pl && pbig |=> dec == 5'h10)
      else $error("pool buffer not taken");
   a_pool_small: assert property (ok && pl && !pbig && !privAvail
      |=> dec == 5'h06) else $error("small pool not refused");
   a_priv_none: assert property (ok && !pl && !privAvail
      |=> dec == 5'h05) else $error("empty list not refused");
   a_priv_head: assert property (ok && !(pl && pbig) && privAvail
      |=> dec == ($past(vbig) ? 5'h08 : 5'h06))
      else $error("private head misjudged");
   a_trib_return: assert property (haltTrib |=> returnTrib)
      else $error("halt returned nothing");
   a_pool_return: assert property (globalHalt |=> returnPool)
      else $error("global halt returned nothing");
   a_fault_post: assert property (nxmValid && !rspValid
      && !$past(msgValid) && !$past(nxmValid) && !$past(babbleExpired)
      && !$past(streamExpired) && !shutDown && linkBlockFree && !hostInit
      |-> ##2 rspValid && rspData == {3'h2, $past(nxmAddr, 2)})
      else $error("fault address not posted");
   a_shut_quiet: assert property (shutDown |-> !rspValid && !nakValid
      && !takePool && !takePriv) else $error("active while shut down");
   a_shut_hold: assert property (shutDown && !hostInit |=> shutDown)
      else $error("shutdown left without init");
   a_boot_invoke: assert property (invokeBoot && bootSwitchEn
      && $past(bootSwitchEn, 2) && !shutDown |=> bootReq && bootReason)
      else $error("boot request missing");
endmodule

bind rx_buffer_ctrl rx_buffer_chk #(.LEN_W(LEN_W), .SEQ_W(SEQ_W),
   .ADDR_W(ADDR_W)) chk (.*);

//--- dv/host_model.sv
`timescale 1ns/1ps
// ****************
// Host retrieving responses
// ****************
module host_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Response side
   input wire logic rspValid,
   input wire logic [20:0] rspData,
   input wire logic [7:0] lag,
   output logic rspTake,
   output logic [20:0] got
);
   logic [7:0] n;
   // One take per posting; a lag of FF outlasts the 50-cycle test window
   always @(negedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rspTake <= 1'b0;
         n <= 8'h00;
         got <= 21'h000000;
      end else if (rspTake) begin
         rspTake <= 1'b0;
         n <= 8'h00;
      end else if (rspValid && n >= lag) begin
         rspTake <= 1'b1;
         got <= rspData;
      end else begin
         n <= rspValid ? n + 8'h01 : 8'h00;
      end
   end
endmodule

//--- dv/sync_link_rx_buffer_and_fault_handling_test.sv
`timescale 1ns/1ps
`include "rx_buffer_defines.vh"
`define CHK(s, e, a) begin check_count++; if ((a) !== (e)) begin \
   errors++; $display("ERROR %s exp %0h got %0h", s, e, a); end end
module sync_link_rx_buffer_and_fault_handling_test;
   logic mclk, rst_n, msgValid, poolEnable, poolQuotaZero, poolAvail;
   logic privAvail, nxmValid, babbleExpired, streamExpired, haltTrib;
   logic globalHalt, linkBlockFree, hostInit, bootSwitchEn, powerOnBootSw;
   logic pollRx, invokeBoot, rspTake, takePool, takePriv, nakValid;
   logic bootReason, returnTrib, returnPool, rspValid, hostIrq;
   logic shutDown, bootReq;
   logic [1:0] nakReason;
   logic [7:0] msgSeq, lag;
   logic [11:0] poolSize, privSize;
   logic [17:0] nxmAddr;
   logic [20:0] rspData, got;
   int errors = 0, check_count = 0, n, k;

   rx_buffer_ctrl #(.RETRIEVE_CYCLES(50)) uut (.*, .msgTrib(4'h0),
      .expSeq(8'h05), .msgLen(12'h064), .haltTribId(4'h0));
   host_model hm (.mclk, .rst_n, .rspValid, .rspData, .lag, .rspTake,
      .got);

   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end

   task automatic pulse(ref logic s);
      @(negedge mclk) s = 1;
      @(negedge mclk) s = 0;
   endtask

   task msg(logic [7:0] s, logic [2:0] p, logic [11:0] ps, logic v,
         logic [11:0] vs, logic [4:0] e);
      @(negedge mclk);
      msgValid = 1;
      msgSeq = s;
      {poolEnable, poolQuotaZero, poolAvail} = p;
      poolSize = ps;
      privAvail = v;
      privSize = vs;
      @(negedge mclk) msgValid = 0;
      `CHK("decision", e, {takePool, takePriv, nakValid,
         nakValid ? nakReason : 2'h0})
   endtask

   task automatic post(ref logic s, input logic [20:0] e, m);
      pulse(s);
      @(negedge mclk) `CHK("irq", 1'b1, hostIrq)
      for (n = 0; n < 20 && !rspTake; n++) @(posedge mclk);
      `CHK("taken", 1'b1, rspTake)
      `CHK("response", e, got & m)
      @(negedge mclk);
   endtask

   task t_boot;
      repeat (3) @(negedge mclk);
      pulse(pollRx);
      `CHK("boot", 2'h2, {bootReq, bootReason})
      pulse(pollRx);
      `CHK("boot", 2'h0, {bootReq, bootReason})
      pulse(invokeBoot);
      `CHK("boot", 2'h3, {bootReq, bootReason})
      bootSwitchEn = 0;
      repeat (4) @(negedge mclk);
      pulse(invokeBoot);
      `CHK("boot", 1'b0, bootReq)
   endtask

   task t_events;
      nxmAddr = 18'h2ABCD;
      post(nxmValid, {`RSP_NXM, 18'h2ABCD}, 21'h1FFFFF);
      post(babbleExpired, {`RSP_BABBLE, 18'h0}, 21'h1C0000);
      post(streamExpired, {`RSP_STREAM, 18'h0}, 21'h1C0000);
   endtask

   task t_halt;
      pulse(haltTrib);
      `CHK("return", 2'h2, {returnTrib, returnPool})
      pulse(globalHalt);
      `CHK("return", 2'h1, {returnTrib, returnPool})
   endtask

   task t_select;
      msg(8'h04, 3'h5, 12'h064, 1, 12'h064, 5'h00);
      msg(8'h05, 3'h5, 12'h064, 0, 12'h000, 5'h10);
      msg(8'h05, 3'h7, 12'h064, 1, 12'h064, 5'h08);
      msg(8'h05, 3'h4, 12'h064, 0, 12'h000, 5'h05);
      msg(8'h05, 3'h5, 12'h063, 0, 12'h000, 5'h06);
      msg(8'h05, 3'h5, 12'h063, 1, 12'h064, 5'h08);
      msg(8'h05, 3'h1, 12'hFFF, 1, 12'h063, 5'h06);
      msg(8'h05, 3'h1, 12'hFFF, 1, 12'hFFF, 5'h08);
      repeat (20) @(negedge mclk);
   endtask

   task t_overflow;
      lag = 8'hFF;
      pulse(nxmValid);
      pulse(babbleExpired);
      pulse(streamExpired);
      @(negedge mclk) linkBlockFree = 0;
      @(negedge mclk) linkBlockFree = 1;
      lag = 8'h01;
      k = 0;
      for (n = 0; n < 60 && !shutDown; n++) @(posedge mclk) k += rspTake;
      `CHK("takes", 3, k)
      `CHK("shut", 1'b1, shutDown)
      msg(8'h05, 3'h5, 12'h064, 0, 12'h000, 5'h00);
      pulse(hostInit);
      `CHK("shut", 1'b0, shutDown)
      lag = 8'hFF;
      pulse(nxmValid);
      @(negedge mclk) linkBlockFree = 0;
      @(negedge mclk) linkBlockFree = 1;
      repeat (40) @(negedge mclk);
      `CHK("shut", 1'b0, shutDown)
      repeat (20) @(negedge mclk);
      `CHK("shut", 1'b1, shutDown)
      pulse(hostInit);
      lag = 8'h00;
   endtask

   task report_and_stop;
      if (errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      {rst_n, msgValid, poolEnable, poolQuotaZero, poolAvail, privAvail,
         nxmValid, babbleExpired, streamExpired, haltTrib, globalHalt,
         hostInit, pollRx, invokeBoot} = '0;
      {linkBlockFree, bootSwitchEn, powerOnBootSw} = 3'h7;
      {msgSeq, lag, poolSize, privSize, nxmAddr} = '0;
      repeat (5) @(negedge mclk);
      rst_n = 1;
      t_boot;
      t_events;
      t_halt;
      t_select;
      t_overflow;
      report_and_stop;
   end

   // Whole run needs well under 1000 cycles
   initial begin
      #50000;
      errors++;
      report_and_stop;
   end
endmodule
